/* core/xcvr_ctl.sv */
// Purpose: control/status pin timing of a pluggable optical transceiver
// Assumes: pins are asynchronous and pass two flip-flops; one clock
// Notes: Avalon-MM slave, one wait state per access
// Operation
// - transmit off rise kills output within 100 us
// - transmit off fall restores output within 2 ms
// - management ready within 300 ms of power
// - non-cooled part operational within 300 ms
// - cooled part operational within 90 s
// - power level two up within 300 ms
// - power level two down within 300 ms
// - fault flag within 1 ms or 50 ms; a fault seen while off is not flagged until run resumes
// - transmit off held 10 us clears fault
// - fibre channel rate stable within 500 us
// - other rate stable within 10 ms
// - signal lost raised within 100 us
// - signal lost dropped within 100 us
`timescale 1ns/1ps
module xcvr_ctl #(
  parameter bit COOLED = 1'b0,
  parameter int unsigned OFF_CYC = xcvr_ctl_pkg::OFF_CYC,
  parameter int unsigned ON_CYC = xcvr_ctl_pkg::ON_CYC,
  parameter int unsigned MGMT_CYC = xcvr_ctl_pkg::MGMT_CYC,
  parameter longint unsigned START_CYC = COOLED ?
    xcvr_ctl_pkg::START_COOLED_CYC : 64'(xcvr_ctl_pkg::START_CYC),
  parameter int unsigned PL2_CYC = xcvr_ctl_pkg::PL2_CYC,
  parameter int unsigned FAULT_CYC = COOLED ?
    xcvr_ctl_pkg::FAULT_COOLED_CYC : xcvr_ctl_pkg::FAULT_CYC,
  parameter int unsigned RESET_CYC = xcvr_ctl_pkg::RESET_CYC,
  parameter int unsigned RS_FC_CYC = xcvr_ctl_pkg::RS_FC_CYC,
  parameter int unsigned RS_CYC = xcvr_ctl_pkg::RS_CYC,
  parameter int unsigned LOS_CYC = xcvr_ctl_pkg::LOS_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // module pins
  input wire logic tx_off_req,
  input wire logic rate_select_low,
  input wire logic rate_select_high,
  input wire logic laser_fault_in,
  input wire logic signal_present,
  output logic tx_enable,
  output logic tx_fault_o,
  output logic tx_fault_oe,
  output logic rx_los,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  localparam int CW = 35;

  // synchronisers: first stage only feeds the second
  // not reset: two edges of reset flush any stale value
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge core_clk) begin
    sync1_q <= {tx_off_req, rate_select_low, rate_select_high,
                laser_fault_in, signal_present};
    sync2_q <= sync1_q;
  end
  // synchronised views, two to three cycles behind the pins
  wire off_s = sync2_q[4];
  wire rsl_s = sync2_q[3];
  wire rsh_s = sync2_q[2];
  wire flt_s = sync2_q[1];
  wire sig_s = sync2_q[0];

  // offsets compared whole: aliases would hide a stray access
  function automatic logic addr_hit(input logic [3:0] ad,
                                    input logic [3:0] off);
    return ad == off;
  endfunction

  // register slave
  // ack_q toggles, so every access sees exactly one wait state
  // a write lands only on the acknowledged cycle, never twice
  logic [31:0] ctrl_q;
  logic ack_q;
  logic [31:0] readdata_q;
  wire req = read | write;
  wire hit_ctrl = addr_hit(address, xcvr_ctl_pkg::REG_CTRL);
  wire hit_stat = addr_hit(address, xcvr_ctl_pkg::REG_STATUS);
  wire wr_ctrl = write & ack_q & hit_ctrl & byteenable[0];
  assign waitrequest = req & ~ack_q;
  assign readdata = readdata_q;
  wire pl2_req = ctrl_q[xcvr_ctl_pkg::CTRL_PL2];
  wire fc_mode = ctrl_q[xcvr_ctl_pkg::CTRL_FC];

  // power-on / management ready counter
  // counter freezes once ready; ready holds until the next reset
  logic [CW-1:0] mgmt_cnt_q;
  logic mgmt_rdy_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mgmt_cnt_q <= '0;
      mgmt_rdy_q <= 1'b0;
    end else if (!mgmt_rdy_q) begin
      mgmt_cnt_q <= mgmt_cnt_q + 1'b1;
      if (mgmt_cnt_q >= CW'(MGMT_CYC - 1)) begin
        mgmt_rdy_q <= 1'b1;
      end
    end
  end

  // transmitter state
  xcvr_ctl_pkg::tx_state_t state_q;
  logic [CW-1:0] st_cnt_q;
  logic [CW-1:0] dis_cnt_q;
  logic [CW-1:0] flt_cnt_q;
  logic fault_q;
  logic oper_q;
  // hold counter saturates at the clear threshold, so a long hold
  // cannot wrap round and look like a short one
  wire clear_held = off_s & (dis_cnt_q >= CW'(RESET_CYC));
  // fault debounce budget: declare once the raw fault has persisted
  // two cycles of the budget are left for the synchroniser
  wire fault_det = flt_s & (flt_cnt_q >= CW'(FAULT_CYC - 2));
  // limitation: a fault seen while off waits for init or run
  wire [CW-1:0] dis_cnt_d = off_s ?
    (clear_held ? dis_cnt_q : dis_cnt_q + 1'b1) : '0;
  wire [CW-1:0] flt_cnt_d = (flt_s && !fault_det) ? flt_cnt_q + 1'b1 : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dis_cnt_q <= '0;
      flt_cnt_q <= '0;
    end else begin
      dis_cnt_q <= dis_cnt_d;
      flt_cnt_q <= flt_cnt_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= xcvr_ctl_pkg::ST_INIT;
      st_cnt_q <= '0;
      fault_q <= 1'b0;
      oper_q <= 1'b0;
    end else begin
      unique case (state_q)
        xcvr_ctl_pkg::ST_INIT: begin
          // start-up: counts from power, insertion or recovery
          // off during init is honoured only once start-up completes
          st_cnt_q <= st_cnt_q + 1'b1;
          if (fault_det) begin
            state_q <= xcvr_ctl_pkg::ST_FAULTED;
            fault_q <= 1'b1;
          end else if (st_cnt_q >= CW'(START_CYC - 1)) begin
            state_q <= off_s ? xcvr_ctl_pkg::ST_OFF : xcvr_ctl_pkg::ST_RUN;
            oper_q <= 1'b1;
            st_cnt_q <= '0;
          end
        end
        xcvr_ctl_pkg::ST_RUN: begin
          if (fault_det) begin
            state_q <= xcvr_ctl_pkg::ST_FAULTED;
            fault_q <= 1'b1;
          end else if (off_s) begin
            state_q <= xcvr_ctl_pkg::ST_OFF;
          end
        end
        xcvr_ctl_pkg::ST_OFF: begin
          // turn-on is immediate, well inside the on-time budget
          if (!off_s) begin
            state_q <= xcvr_ctl_pkg::ST_RUN;
          end
        end
        xcvr_ctl_pkg::ST_FAULTED: begin
          // latched until host holds transmit off long enough
          // recovery restarts the full start-up interval
          if (clear_held) begin
            fault_q <= 1'b0;
            oper_q <= 1'b0;
            st_cnt_q <= '0;
            state_q <= xcvr_ctl_pkg::ST_INIT;
          end
        end
      endcase
    end
  end

  // output is on only when running and request low; off within 3 cycles
  assign tx_enable = (state_q == xcvr_ctl_pkg::ST_RUN) & ~off_s;
  // open-drain fault: drive low when clear, release to pull-up on fault
  assign tx_fault_o = 1'b0;
  assign tx_fault_oe = ~fault_q;

  // power level two: settles the whole budget, PL2_CYC cycles, after the write
  // a request reversed mid-way restarts the timer from zero
  // trade-off: fixed delay, no handshake with the power stage
  logic pl2_q;
  logic [CW-1:0] pl2_cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pl2_q <= 1'b0;
      pl2_cnt_q <= '0;
    end else if (pl2_q == pl2_req) begin
      pl2_cnt_q <= '0;
    end else if (pl2_cnt_q >= CW'(PL2_CYC - 1)) begin
      pl2_q <= pl2_req;
      pl2_cnt_q <= '0;
    end else begin
      pl2_cnt_q <= pl2_cnt_q + 1'b1;
    end
  end

  // rate select: output re-stabilises after a change on either input
  // fc mode picks the shorter budget; a mode write alone is no event
  // previous value resets to the idle pins, so no false edge
  logic [1:0] rs_prev_q;
  logic [CW-1:0] rs_cnt_q;
  logic rate_ok_q;
  wire rs_change = rs_prev_q != {rsh_s, rsl_s};
  wire [CW-1:0] rs_limit = fc_mode ? CW'(RS_FC_CYC - 1) : CW'(RS_CYC - 1);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rs_prev_q <= 2'b00;
      rs_cnt_q <= '0;
      rate_ok_q <= 1'b1;
    end else begin
      rs_prev_q <= {rsh_s, rsl_s};
      if (rs_change) begin
        rate_ok_q <= 1'b0;
        rs_cnt_q <= '0;
      end else if (!rate_ok_q) begin
        if (rs_cnt_q >= rs_limit) begin
          rate_ok_q <= 1'b1;
        end else begin
          rs_cnt_q <= rs_cnt_q + 1'b1;
        end
      end
    end
  end

  // loss of signal with a short filter well inside the budget
  // half the budget leaves room for the synchroniser and the flip
  // reset value is lost: no signal is claimed until one is seen
  logic [CW-1:0] los_cnt_q;
  logic los_q;
  wire los_limit = los_cnt_q >= CW'(LOS_CYC / 2);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      los_q <= 1'b1;
      los_cnt_q <= '0;
    end else if (sig_s == los_q) begin
      // input disagrees with output: count toward a flip
      if (los_limit) begin
        los_q <= ~sig_s;
        los_cnt_q <= '0;
      end else begin
        los_cnt_q <= los_cnt_q + 1'b1;
      end
    end else begin
      los_cnt_q <= '0;
    end
  end
  assign rx_los = los_q;

  // bus access: one wait state, then ack; unmapped reads return zero
  // status word built from the package field positions
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[xcvr_ctl_pkg::ST_TX_ON] = tx_enable;
    status_w[xcvr_ctl_pkg::ST_FAULT] = fault_q;
    status_w[xcvr_ctl_pkg::ST_LOS] = los_q;
    status_w[xcvr_ctl_pkg::ST_MGMT_RDY] = mgmt_rdy_q;
    status_w[xcvr_ctl_pkg::ST_OPER] = oper_q;
    status_w[xcvr_ctl_pkg::ST_PL2] = pl2_q;
    status_w[xcvr_ctl_pkg::ST_RATE_OK] = rate_ok_q;
    status_w[xcvr_ctl_pkg::ST_STATE +: 2] = state_q;
  end
  // reads capture on the first cycle, so data stand at the ack
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q : (hit_stat ? status_w : 32'h0);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0;
      ctrl_q <= xcvr_ctl_pkg::CTRL_RESET;
    end else begin
      ack_q <= req & ~ack_q;
      if (read & ~ack_q) readdata_q <= rd_mux;
      if (wr_ctrl) ctrl_q <= {30'h0, writedata[1:0]};
    end
  end
endmodule

/* core/xcvr_ctl_pkg.sv */
// Purpose: constants for the transceiver control and status timing block
// Assumes: core_clk at 200 MHz
// Notes: times kept in their own unit, cycle counts derived from them
package xcvr_ctl_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned T_OFF_US = 100;
  localparam int unsigned T_ON_MS = 2;
  localparam int unsigned T_MGMT_MS = 300;
  localparam int unsigned T_START_MS = 300;
  localparam int unsigned T_START_COOLED_S = 90;
  localparam int unsigned T_PL2_MS = 300;
  localparam int unsigned T_FAULT_MS = 1;
  localparam int unsigned T_FAULT_COOLED_MS = 50;
  localparam int unsigned T_RESET_US = 10;
  localparam int unsigned T_RS_FC_US = 500;
  localparam int unsigned T_RS_MS = 10;
  localparam int unsigned T_LOS_US = 100;
  // longest times round down, least time rounds up (exact here)
  localparam int unsigned OFF_CYC = T_OFF_US * CLK_MHZ;
  localparam int unsigned ON_CYC = T_ON_MS * 1000 * CLK_MHZ;
  localparam int unsigned MGMT_CYC = T_MGMT_MS * 1000 * CLK_MHZ;
  localparam int unsigned START_CYC = T_START_MS * 1000 * CLK_MHZ;
  localparam longint unsigned START_COOLED_CYC =
    64'(T_START_COOLED_S) * 1000000 * CLK_MHZ;
  localparam int unsigned PL2_CYC = T_PL2_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAULT_CYC = T_FAULT_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAULT_COOLED_CYC =
    T_FAULT_COOLED_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESET_CYC = T_RESET_US * CLK_MHZ;
  localparam int unsigned RS_FC_CYC = T_RS_FC_US * CLK_MHZ;
  localparam int unsigned RS_CYC = T_RS_MS * 1000 * CLK_MHZ;
  localparam int unsigned LOS_CYC = T_LOS_US * CLK_MHZ;

  // register byte offsets on the Avalon-MM slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // control bits
  localparam int unsigned CTRL_PL2 = 0;
  localparam int unsigned CTRL_FC = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status bits
  localparam int unsigned ST_TX_ON = 0;
  localparam int unsigned ST_FAULT = 1;
  localparam int unsigned ST_LOS = 2;
  localparam int unsigned ST_MGMT_RDY = 3;
  localparam int unsigned ST_OPER = 4;
  localparam int unsigned ST_PL2 = 5;
  localparam int unsigned ST_RATE_OK = 6;
  localparam int unsigned ST_STATE = 8;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULTED = 2'b10,
    ST_OFF = 2'b11
  } tx_state_t;
endpackage

/* tb/xcvr_ctl_monitor.sv */
// Purpose: port timing checks for the transceiver control block
// Assumes: shortened counts handed on by the bind
// Notes: run counters give the signal-lost, fault and ready latencies a hard bound
`timescale 1ns/1ps
module xcvr_ctl_monitor #(
  parameter int unsigned MGMT_CYC = 50,
  parameter int unsigned FAULT_CYC = 10,
  parameter int unsigned RESET_CYC = 8,
  parameter int unsigned LOS_CYC = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic tx_off_req,
  input wire logic laser_fault_in,
  input wire logic signal_present,
  input wire logic tx_enable,
  input wire logic tx_fault_oe,
  input wire logic rx_los,
  // bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  int unsigned up_q, lo_q, hi_q, flt_q, off_q;
  function automatic int unsigned run(int unsigned c, logic on);
    return on ? (c < 999 ? c + 1 : c) : 0;
  endfunction
  always_ff @(posedge core_clk) begin
    up_q <= rst ? 0 : run(up_q, 1'b1);
    lo_q <= rst ? 0 : run(lo_q, !signal_present);
    hi_q <= rst ? 0 : run(hi_q, signal_present);
    flt_q <= rst ? 0 : run(flt_q, laser_fault_in && !tx_off_req);
    off_q <= rst ? 0 : run(off_q, tx_off_req);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("request answered without a wait state");
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait state");
  a_unmapped_zero: assert property (read && !waitrequest && address != 4'h0
    && address != 4'h4 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_off_kills_tx: assert property (tx_off_req [*3] |-> !tx_enable)
    else $error("transmitter on while off requested");
  a_los_raise: assert property (lo_q > LOS_CYC + 3 |-> rx_los)
    else $error("signal lost flag late");
  a_los_drop: assert property (hi_q > LOS_CYC + 3 |-> !rx_los)
    else $error("signal lost flag stuck");
  a_fault_flag: assert property (flt_q > FAULT_CYC + 6 |-> !tx_fault_oe)
    else $error("fault flag late");
  a_fault_clear: assert property (off_q == RESET_CYC + 4
    && !laser_fault_in |-> tx_fault_oe)
    else $error("fault flag not cleared");
  a_mgmt_ready: assert property (read && !waitrequest && address == 4'h4
    && up_q > MGMT_CYC + 4 |-> readdata[xcvr_ctl_pkg::ST_MGMT_RDY])
    else $error("management not ready in time");
endmodule
bind xcvr_ctl xcvr_ctl_monitor #(.MGMT_CYC(MGMT_CYC), .FAULT_CYC(FAULT_CYC),
  .RESET_CYC(RESET_CYC), .LOS_CYC(LOS_CYC)) xcvr_ctl_monitor_inst (
  .core_clk, .rst, .tx_off_req, .laser_fault_in, .signal_present,
  .tx_enable, .tx_fault_oe, .rx_los, .address, .read, .write, .readdata,
  .waitrequest);

/* tb/host_pins.sv */
// Purpose: host side of the transmit off and fault pins
// Assumes: bench commands the off request as a level
// Notes: open pin at power-up reads as off
`timescale 1ns/1ps
module host_pins #(
  parameter int unsigned HOLD = 14
) (
  // clock
  input wire logic core_clk,
  // bench command
  input wire logic off_cmd,
  // module pins
  input wire logic tx_fault_o,
  input wire logic tx_fault_oe,
  output logic tx_off_req,
  output logic fault_line
);
  logic off_q = 1'b1;
  int unsigned held_q = 0;
  assign tx_off_req = off_q;
  // released open-drain line sits at the pull-up
  assign fault_line = tx_fault_oe ? tx_fault_o : 1'b1;
  // a raised request is kept long enough to reset a fault
  always @(posedge core_clk) begin
    held_q <= off_q ? held_q + 1 : 0;
    off_q <= off_cmd || (off_q && held_q < HOLD);
  end
endmodule

/* tb/test_xcvr_ctl.sv */
// Purpose: self-checking bench for the transceiver control block
// Assumes: counts shortened through parameters
// Notes: random signal loss and unmapped traffic mixed in
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_xcvr_ctl;
  localparam int unsigned STRT = 40, FLT = 10, RST = 8, LOS = 16;
  logic core_clk, rst, off_cmd, tx_off_req, rate_select_low;
  logic rate_select_high, laser_fault_in, signal_present, tx_enable;
  logic tx_fault_o, tx_fault_oe, rx_los, fault_line, read, write;
  logic waitrequest;
  logic [3:0] address, a;
  logic [31:0] writedata, readdata, st;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  xcvr_ctl #(.MGMT_CYC(50), .START_CYC(STRT), .PL2_CYC(30), .FAULT_CYC(FLT),
    .RESET_CYC(RST), .RS_FC_CYC(12), .RS_CYC(20), .LOS_CYC(LOS))
    xcvr_ctl_inst (.core_clk, .rst, .tx_off_req, .rate_select_low,
    .rate_select_high, .laser_fault_in, .signal_present, .tx_enable,
    .tx_fault_o, .tx_fault_oe, .rx_los, .address, .read, .write,
    .writedata, .byteenable(4'hf), .readdata, .waitrequest);
  host_pins #(.HOLD(RST + 6)) host_pins_inst (.core_clk, .off_cmd,
    .tx_fault_o, .tx_fault_oe, .tx_off_req, .fault_line);
  // allowance for pin sync and poll spacing
  function automatic int lim(int n);
    return n + 8;
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    address <= ad;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge core_clk iff !waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic ctrl(input logic [31:0] d);
    bus(1'b1, xcvr_ctl_pkg::REG_CTRL, d, st);
  endtask
  task automatic poll(input int b, input logic v, input int n);
    int t0;
    logic [31:0] q;
    t0 = cyc;
    do bus(1'b0, xcvr_ctl_pkg::REG_STATUS, 32'h0, q);
    while (q[b] !== v && cyc - t0 < n);
    `CHK("status bit", v, q[b])
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'hd740));
    {rst, off_cmd, signal_present} = 3'b111;
    {rate_select_low, rate_select_high, laser_fault_in, read, write} = 5'h0;
    address = 4'h0;
    writedata = 32'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    off_cmd <= 1'b0;
    poll(xcvr_ctl_pkg::ST_MGMT_RDY, 1'b0, 0);
    poll(xcvr_ctl_pkg::ST_OPER, 1'b1, lim(STRT));
    poll(xcvr_ctl_pkg::ST_MGMT_RDY, 1'b1, lim(50));
    `CHK("tx_enable", 1'b1, tx_enable)
    off_cmd <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK("tx_enable", 1'b0, tx_enable)
    off_cmd <= 1'b0;
    repeat (RST + 14) @(posedge core_clk);
    `CHK("tx_enable", 1'b1, tx_enable)
    ctrl(32'h1 << xcvr_ctl_pkg::CTRL_PL2);
    poll(xcvr_ctl_pkg::ST_PL2, 1'b1, lim(30));
    ctrl(32'h0);
    poll(xcvr_ctl_pkg::ST_PL2, 1'b0, lim(30));
    ctrl(32'h1 << xcvr_ctl_pkg::CTRL_FC);
    rate_select_low <= 1'b1;
    poll(xcvr_ctl_pkg::ST_RATE_OK, 1'b0, 4);
    poll(xcvr_ctl_pkg::ST_RATE_OK, 1'b1, lim(12));
    ctrl(32'h0);
    rate_select_high <= 1'b1;
    poll(xcvr_ctl_pkg::ST_RATE_OK, 1'b0, 4);
    poll(xcvr_ctl_pkg::ST_RATE_OK, 1'b1, lim(20));
    laser_fault_in <= 1'b1;
    repeat (FLT + 8) @(posedge core_clk);
    `CHK("fault_line", 1'b1, fault_line)
    laser_fault_in <= 1'b0;
    off_cmd <= 1'b1;
    @(posedge core_clk);
    off_cmd <= 1'b0;
    repeat (RST + 10) @(posedge core_clk);
    `CHK("fault_line", 1'b0, fault_line)
    poll(xcvr_ctl_pkg::ST_OPER, 1'b1, lim(STRT));
    signal_present <= 1'b0;
    repeat (LOS + 6) @(posedge core_clk);
    `CHK("rx_los", 1'b1, rx_los)
    signal_present <= 1'b1;
    repeat (LOS + 6) @(posedge core_clk);
    `CHK("rx_los", 1'b0, rx_los)
    repeat (30) begin
      signal_present <= 1'($urandom);
      a = 4'($urandom);
      if (a == 4'h0 || a == 4'h4) a = 4'h9;
      bus(1'b1, a, $urandom, st);
      bus(1'b0, a, 32'h0, st);
      `CHK("unmapped", 32'h0, st)
      repeat ($urandom_range(0, 40)) @(posedge core_clk);
    end
    stop_test();
  end
endmodule
